// ---- rtl/qcfg_pkg.sv ----
// Package for the charge converter test and configuration register bank
package qcfg_pkg;
    localparam logic [15:0] OFS_MODE_SET = 16'h1032;
    localparam logic [15:0] OFS_MODE_CLR = 16'h1034;
    localparam logic [15:0] OFS_MT_WADDR = 16'h1036;
    localparam logic [15:0] OFS_TW_UPPER = 16'h1038;
    localparam logic [15:0] OFS_TW_LOWER = 16'h103a;
    localparam logic [15:0] OFS_CRATE = 16'h103c;
    localparam logic [15:0] OFS_TEST_EVT = 16'h103e;
    localparam logic [15:0] OFS_EVCNT_CLR = 16'h1040;
    localparam logic [15:0] OFS_PED = 16'h1060;
    localparam logic [15:0] OFS_MT_RADDR = 16'h1064;
    localparam logic [15:0] OFS_TEST_CONV = 16'h1068;
    localparam logic [15:0] OFS_SLIDE = 16'h106a;
    localparam logic [15:0] OFS_ADC_A = 16'h1070;
    localparam logic [15:0] OFS_ADC_B = 16'h1072;
    localparam logic [15:0] OFS_THR_BASE = 16'h1080;
    localparam logic [15:0] OFS_THR_LAST = 16'h10be;
    localparam logic [15:0] OFS_ROM_BASE = 16'h8000;
    localparam logic [15:0] OFS_MAKER_H = 16'h8026;
    localparam logic [15:0] OFS_MAKER_M = 16'h802a;
    localparam logic [15:0] OFS_MAKER_L = 16'h802e;
    localparam logic [15:0] OFS_VARIANT = 16'h8032;
    localparam logic [15:0] OFS_BOARD_H = 16'h8036;
    localparam logic [15:0] OFS_BOARD_M = 16'h803a;
    localparam logic [15:0] OFS_BOARD_L = 16'h803e;
    localparam logic [15:0] OFS_HWREV = 16'h804e;
    localparam logic [15:0] OFS_SER_H = 16'h8f02;
    localparam logic [15:0] OFS_SER_L = 16'h8f06;
    // Mode bit positions
    localparam int MODE_MEM_TEST = 0;
    localparam int MODE_DATA_CLR = 2;
    localparam int MODE_ACQ_TEST = 6;
    localparam int MODE_SLIDE_EN = 7;
    localparam logic [15:0] MODE_RST = 16'h4880;
    localparam logic [7:0] PED_RST = 8'hb4;
    localparam int THR_KILL = 8;
    localparam int EVT_OVF = 12;
    localparam int FIFO_DEPTH = 32;
    localparam int ADDR_W = 11;
    // Arbitrary neutral identity values
    localparam logic [7:0] ID_MAKER_H = 8'h5a;
    localparam logic [7:0] ID_MAKER_M = 8'h5b;
    localparam logic [7:0] ID_MAKER_L = 8'h5c;
    localparam logic [7:0] ID_VARIANT = 8'h01;
    localparam logic [7:0] ID_BOARD_H = 8'h0a;
    localparam logic [7:0] ID_BOARD_M = 8'h0b;
    localparam logic [7:0] ID_BOARD_L = 8'h0c;
    localparam logic [7:0] ID_HWREV = 8'h01;
    localparam logic [7:0] ID_SER_H = 8'h00;
    localparam logic [7:0] ID_SER_L = 8'h01;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } qcfg_req_t;

    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [31:0] data;
    } qcfg_memwr_t;
endpackage : qcfg_pkg

// ---- rtl/qcfg_regs.sv ----
// Test and configuration register bank of the charge converter board
//
// What this block does
// - Mode-clear write clears bits written as one
// - Zeros in mode-clear change nothing
// - Write-only memory-test write address register
// - Lower-half write in memory-test mode commits 32-bit test word, unless a replay takes that cycle
// - Crate number register, read/write, into data
// - Test-event write pushes 32-entry FIFO
// - Test word: 12-bit value plus overflow
// - Words replayed in write order 0,1,2
// - Any counter-clear write zeroes event counter
// - 8-bit pedestal setting, default 180
// - Write-only memory-test read address register
// - Test-conversion write launches one conversion
// - Slide constant drives DAC when disabled
// - Two read-only ADC block values
// - Threshold entries 0x1080 to 0x10be
// - Kill bit blocks channel storage
// - Thresholds not cleared by any reset
// - ROM returns identification bytes
// - ROM returns serial high and low
// - Mode-set write sets bits written one
// - Data-clear bit resets data and counter
// - Acquisition test feeds buffer from FIFO
`timescale 1ns/100ps
module qcfg_regs (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hw_rst_in,
    input wire qcfg_pkg::qcfg_req_t req_in,
    input wire logic narrow_variant_in,
    input wire logic gate_in,
    input wire logic evt_inc_in,
    input wire logic [15:0] adc_a_in,
    input wire logic [15:0] adc_b_in,
    input wire logic [4:0] thr_sel_in,
    output logic [15:0] rdata_out,
    output logic [15:0] mode_out,
    output logic [7:0] crate_out,
    output logic [7:0] ped_out,
    output logic [7:0] dac_out,
    output logic conv_start_out,
    output logic data_clear_out,
    output logic [23:0] evt_count_out,
    output logic [qcfg_pkg::ADDR_W-1:0] mt_raddr_out,
    output qcfg_pkg::qcfg_memwr_t memwr_out,
    output logic [15:0] thr_out,
    output logic thr_kill_out
);
    localparam int ADDR_W_O = qcfg_pkg::ADDR_W;

    // =======================================
    // Pin synchronisers
    // =======================================
    logic [1:0] gate_s_r;
    logic [15:0] adc_a_s1_r;
    logic [15:0] adc_a_s2_r;
    logic [15:0] adc_b_s1_r;
    logic [15:0] adc_b_s2_r;
    logic gate_d_r;

    // Gate pin, reset to its idle low level so no false edge follows
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            gate_s_r <= 2'h0;
            gate_d_r <= 1'b0;
        end else begin
            gate_s_r <= {gate_s_r[0], gate_in};
            gate_d_r <= gate_s_r[1];
        end
    end

    // Converter words; a read during an update may see a torn word
    always_ff @(posedge clk_in) begin
        adc_a_s1_r <= adc_a_in;
        adc_a_s2_r <= adc_a_s1_r;
    end

    always_ff @(posedge clk_in) begin
        adc_b_s1_r <= adc_b_in;
        adc_b_s2_r <= adc_b_s1_r;
    end

    wire logic gate_rise = gate_s_r[1] & ~gate_d_r;

    // =======================================
    // Address decode
    // =======================================
    function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    function automatic logic wr_hit(input qcfg_pkg::qcfg_req_t r, input logic [15:0] ofs);
        wr_hit = r.wr && hit(r.addr, ofs);
    endfunction : wr_hit

    wire logic wr = req_in.wr;
    wire logic [15:0] a = req_in.addr;
    wire logic [15:0] d = req_in.wdata;
    // Stored widths: sample plus overflow flag, threshold plus kill flag
    localparam logic [15:0] EVT_MASK = 16'((32'h1 << (qcfg_pkg::EVT_OVF + 1)) - 32'h1);
    localparam logic [15:0] THR_MASK = 16'((32'h1 << (qcfg_pkg::THR_KILL + 1)) - 32'h1);
    wire logic [15:0] thr_off = a - qcfg_pkg::OFS_THR_BASE;
    wire logic thr_hit = (a >= qcfg_pkg::OFS_THR_BASE) && (a <= qcfg_pkg::OFS_THR_LAST)
        && !a[0] && (!narrow_variant_in || !a[1]);
    // Stride 2 or 4 by variant
    wire logic [4:0] thr_idx = narrow_variant_in ? {1'b0, thr_off[5:2]} : thr_off[5:1];

    // =======================================
    // Mode register
    // =======================================
    logic [15:0] mode_r;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            mode_r <= qcfg_pkg::MODE_RST;
        end else if (wr && hit(a, qcfg_pkg::OFS_MODE_SET)) begin
            mode_r <= mode_r | d;
        end else if (wr && hit(a, qcfg_pkg::OFS_MODE_CLR)) begin
            mode_r <= mode_r & ~d;
        end
    end

    always_ff @(posedge clk_in) begin
        mode_out <= mode_r;
        data_clear_out <= mode_r[qcfg_pkg::MODE_DATA_CLR];
    end

    // =======================================
    // Plain configuration registers
    // =======================================
    logic [7:0] crate_r;
    logic [7:0] ped_r;
    logic [7:0] slide_r;
    logic [ADDR_W_O-1:0] mt_waddr_r;
    logic [ADDR_W_O-1:0] mt_raddr_r;
    logic [15:0] tw_upper_r;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            crate_r <= 8'h00;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_CRATE)) begin
            crate_r <= d[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            ped_r <= qcfg_pkg::PED_RST;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_PED)) begin
            ped_r <= d[7:0];
        end
    end

    // Slide constant
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            slide_r <= 8'h00;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_SLIDE)) begin
            slide_r <= d[7:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            mt_waddr_r <= '0;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_MT_WADDR)) begin
            mt_waddr_r <= d[ADDR_W_O-1:0];
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            mt_raddr_r <= '0;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_MT_RADDR)) begin
            mt_raddr_r <= d[ADDR_W_O-1:0];
        end
    end

    // Upper half of the test word
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            tw_upper_r <= 16'h0000;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_TW_UPPER)) begin
            tw_upper_r <= d;
        end
    end

    always_ff @(posedge clk_in) begin
        crate_out <= crate_r;
        ped_out <= ped_r;
        mt_raddr_out <= mt_raddr_r;
    end

    // Constant to DAC when sliding disabled
    always_ff @(posedge clk_in) begin
        if (mode_r[qcfg_pkg::MODE_SLIDE_EN]) begin
            dac_out <= 8'h00;
        end else begin
            dac_out <= slide_r;
        end
    end

    // =======================================
    // Test event FIFO storage
    // =======================================
    logic [15:0] fifo_mem [qcfg_pkg::FIFO_DEPTH];
    logic [4:0] fifo_wr_r;
    logic [4:0] fifo_rd_r;
    logic acq_d_r;

    wire logic acq_mode = mode_r[qcfg_pkg::MODE_ACQ_TEST];
    // Each edge of the test bit restarts both pointers
    wire logic acq_toggle = acq_mode != acq_d_r;
    wire logic replay = gate_rise && acq_mode;

    always_ff @(posedge clk_in) begin
        // Push masked word in write order
        if (wr_hit(req_in, qcfg_pkg::OFS_TEST_EVT)) begin
            fifo_mem[fifo_wr_r] <= d & EVT_MASK;
        end
    end

    // =======================================
    // Memory test commit and strobes
    // =======================================
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            memwr_out <= '0;
        end else begin
            memwr_out.wr <= wr_hit(req_in, qcfg_pkg::OFS_TW_LOWER)
                && mode_r[qcfg_pkg::MODE_MEM_TEST];
            memwr_out.addr <= mt_waddr_r;
            memwr_out.data <= {tw_upper_r, d};
            if (replay) begin
                memwr_out.wr <= 1'b1;
                memwr_out.addr <= {6'h00, fifo_rd_r};
                memwr_out.data <= {16'h0000, fifo_mem[fifo_rd_r]};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            conv_start_out <= 1'b0;
        end else begin
            conv_start_out <= wr_hit(req_in, qcfg_pkg::OFS_TEST_CONV);
        end
    end

    // =======================================
    // Test event FIFO pointers
    // =======================================
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            acq_d_r <= 1'b0;
        end else begin
            acq_d_r <= acq_mode;
        end
    end

    // Write pointer wraps after 32 words
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in || acq_toggle) begin
            fifo_wr_r <= 5'h00;
        end else if (wr_hit(req_in, qcfg_pkg::OFS_TEST_EVT)) begin
            fifo_wr_r <= fifo_wr_r + 5'h01;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in || acq_toggle) begin
            fifo_rd_r <= 5'h00;
        end else if (replay) begin
            fifo_rd_r <= fifo_rd_r + 5'h01;
        end
    end

    // =======================================
    // Event counter
    // =======================================
    logic [23:0] evt_cnt_r;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            evt_cnt_r <= 24'h000000;
        // Clear on write or data clear
        end else if ((wr && hit(a, qcfg_pkg::OFS_EVCNT_CLR))
                || mode_r[qcfg_pkg::MODE_DATA_CLR]) begin
            evt_cnt_r <= 24'h000000;
        end else if (evt_inc_in) begin
            evt_cnt_r <= evt_cnt_r + 24'h000001;
        end
    end

    always_ff @(posedge clk_in) begin
        evt_count_out <= evt_cnt_r;
    end

    // =======================================
    // Threshold memory
    // =======================================
    logic [15:0] thr_mem [qcfg_pkg::FIFO_DEPTH];

    // Only software writes, no reset here
    always_ff @(posedge clk_in) begin
        if (wr && thr_hit) begin
            thr_mem[thr_idx] <= d & THR_MASK;
        end
    end

    always_ff @(posedge clk_in) begin
        thr_out <= thr_mem[thr_sel_in];
        thr_kill_out <= thr_mem[thr_sel_in][qcfg_pkg::THR_KILL];
    end

    // =======================================
    // Read mux
    // =======================================
    logic [15:0] rd_nxt;

    always_comb begin
        rd_nxt = 16'h0000;
        if (thr_hit) begin
            rd_nxt = thr_mem[thr_idx];
        end else begin
            unique case (a)
                qcfg_pkg::OFS_MODE_SET: rd_nxt = mode_r;
                qcfg_pkg::OFS_CRATE: rd_nxt = {8'h00, crate_r};
                qcfg_pkg::OFS_PED: rd_nxt = {8'h00, ped_r};
                qcfg_pkg::OFS_SLIDE: rd_nxt = {8'h00, slide_r};
                qcfg_pkg::OFS_ADC_A: rd_nxt = adc_a_s2_r;
                qcfg_pkg::OFS_ADC_B: rd_nxt = adc_b_s2_r;
                qcfg_pkg::OFS_MAKER_H: rd_nxt = {8'h00, qcfg_pkg::ID_MAKER_H};
                qcfg_pkg::OFS_MAKER_M: rd_nxt = {8'h00, qcfg_pkg::ID_MAKER_M};
                qcfg_pkg::OFS_MAKER_L: rd_nxt = {8'h00, qcfg_pkg::ID_MAKER_L};
                qcfg_pkg::OFS_VARIANT: rd_nxt = {8'h00, qcfg_pkg::ID_VARIANT};
                qcfg_pkg::OFS_BOARD_H: rd_nxt = {8'h00, qcfg_pkg::ID_BOARD_H};
                qcfg_pkg::OFS_BOARD_M: rd_nxt = {8'h00, qcfg_pkg::ID_BOARD_M};
                qcfg_pkg::OFS_BOARD_L: rd_nxt = {8'h00, qcfg_pkg::ID_BOARD_L};
                qcfg_pkg::OFS_HWREV: rd_nxt = {8'h00, qcfg_pkg::ID_HWREV};
                qcfg_pkg::OFS_SER_H: rd_nxt = {8'h00, qcfg_pkg::ID_SER_H};
                qcfg_pkg::OFS_SER_L: rd_nxt = {8'h00, qcfg_pkg::ID_SER_L};
                default: rd_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || hw_rst_in) begin
            rdata_out <= 16'h0000;
        end else if (req_in.rd) begin
            rdata_out <= rd_nxt;
        end
    end
endmodule : qcfg_regs

// ---- testbench/qcfg_regs_checker.sv ----
// Port assertions for the register bank
`timescale 1ns/100ps
module qcfg_regs_checker (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic hw_rst_in,
    input wire qcfg_pkg::qcfg_req_t req_in,
    input wire logic evt_inc_in,
    input wire logic [15:0] mode_out,
    input wire logic [7:0] dac_out,
    input wire logic conv_start_out,
    input wire logic data_clear_out,
    input wire logic [23:0] evt_count_out,
    input wire qcfg_pkg::qcfg_memwr_t memwr_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in || hw_rst_in);
    wire wr_set = req_in.wr && req_in.addr == qcfg_pkg::OFS_MODE_SET;
    wire wr_clr = req_in.wr && req_in.addr == qcfg_pkg::OFS_MODE_CLR;
    wire wr_low = req_in.wr && req_in.addr == qcfg_pkg::OFS_TW_LOWER;
    wire wr_conv = req_in.wr && req_in.addr == qcfg_pkg::OFS_TEST_CONV;
    wire wr_evc = req_in.wr && req_in.addr == qcfg_pkg::OFS_EVCNT_CLR;
    a_clear_ones: assert property (
        wr_clr |-> ##2 (mode_out & $past(req_in.wdata, 2)) == 16'h0000)
        else $error("mode clear left a bit set");
    a_clear_keep: assert property (
        wr_clr |-> ##2 (mode_out & ~$past(req_in.wdata, 2))
            == ($past(mode_out) & ~$past(req_in.wdata, 2)))
        else $error("mode clear changed an unselected bit");
    a_set_ones: assert property (
        wr_set |-> ##2 (mode_out & $past(req_in.wdata, 2)) == $past(req_in.wdata, 2))
        else $error("mode set missed a bit");
    a_conv_pulse: assert property (wr_conv |=> conv_start_out)
        else $error("no conversion start");
    a_conv_cause: assert property (conv_start_out |-> $past(wr_conv))
        else $error("spurious conversion start");
    a_evcnt_zero: assert property (
        wr_evc && !evt_inc_in ##1 !evt_inc_in |=> evt_count_out == 24'h000000)
        else $error("event counter not cleared");
    a_dac_hold: assert property (mode_out[7] [*2] |-> dac_out == 8'h00)
        else $error("dac driven while sliding enabled");
    a_clear_out: assert property (
        $stable(mode_out) [*2] |-> data_clear_out == mode_out[2])
        else $error("data clear output mismatch");
    a_word_commit: assert property (
        wr_low && mode_out[0] |=> memwr_out.wr && memwr_out.data[15:0] == $past(req_in.wdata))
        else $error("test word not committed");
endmodule : qcfg_regs_checker

// ---- testbench/qcfg_host.sv ----
// Host master model issuing register requests
`timescale 1ns/100ps
module qcfg_host (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    output qcfg_pkg::qcfg_req_t req_out
);
    initial req_out = '{wr: 1'b0, rd: 1'b0, addr: 16'hffff, wdata: 16'hffff};
    // One-cycle request, then address and data scrambled
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(negedge clk_in);
        req_out <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [15:0] q);
        xfer(1'b0, a, 16'h0000);
        @(negedge clk_in);
        q = rdata_in;
    endtask : rd
endmodule : qcfg_host

// ---- testbench/tb_qcfg_regs.sv ----
// Self-checking bench for the register bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_qcfg_regs;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, narrow = 1'b0, gate = 1'b0, inc = 1'b0;
    logic hw_rst = 1'b0;
    logic [15:0] adc_a = 16'h0abc, adc_b = 16'h0def, rdata, mode, thr, q;
    logic [7:0] crate, ped, dac;
    logic [4:0] thr_sel = 5'h00;
    logic conv, dclr, kill;
    logic [23:0] evc;
    logic [10:0] mt_raddr;
    qcfg_pkg::qcfg_req_t req;
    qcfg_pkg::qcfg_memwr_t memwr, mw_q, mw_a;
    int num_errors = 0, checks_done = 0, mw_n = 0, cv_n = 0;
    localparam logic [15:0] RA [10] = '{16'h8026, 16'h802a, 16'h802e, 16'h8032, 16'h8036,
        16'h803a, 16'h803e, 16'h804e, 16'h8f02, 16'h8f06};
    localparam logic [7:0] RV [10] = '{qcfg_pkg::ID_MAKER_H, qcfg_pkg::ID_MAKER_M,
        qcfg_pkg::ID_MAKER_L, qcfg_pkg::ID_VARIANT, qcfg_pkg::ID_BOARD_H, qcfg_pkg::ID_BOARD_M,
        qcfg_pkg::ID_BOARD_L, qcfg_pkg::ID_HWREV, qcfg_pkg::ID_SER_H, qcfg_pkg::ID_SER_L};
    qcfg_host host_u (.clk_in(clk_in), .rdata_in(rdata), .req_out(req));
    qcfg_regs dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .hw_rst_in(hw_rst), .req_in(req),
        .narrow_variant_in(narrow), .gate_in(gate), .evt_inc_in(inc), .adc_a_in(adc_a),
        .adc_b_in(adc_b), .thr_sel_in(thr_sel), .rdata_out(rdata), .mode_out(mode),
        .crate_out(crate), .ped_out(ped), .dac_out(dac), .conv_start_out(conv),
        .data_clear_out(dclr), .evt_count_out(evc), .mt_raddr_out(mt_raddr),
        .memwr_out(memwr), .thr_out(thr), .thr_kill_out(kill));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (memwr.wr === 1'b1) begin
            mw_n++;
            mw_q = memwr;
            if (mw_n == 2) mw_a = memwr;
        end
        if (conv === 1'b1) cv_n++;
    end
    task automatic rc(input logic [15:0] a, input logic [15:0] e);
        host_u.rd(a, q);
        `CHK($sformatf("reg %h", a), e, q)
    endtask : rc
    task automatic wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wt
    task automatic results;
        if (num_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial begin
        #200us;
        num_errors++;
        results;
    end
    // ==========
    // Main sequence
    initial begin
        wt(3);
        sys_rst_in = 1'b0;
        rc(qcfg_pkg::OFS_MODE_SET, qcfg_pkg::MODE_RST);
        rc(qcfg_pkg::OFS_PED, 16'h00b4);
        host_u.wr(qcfg_pkg::OFS_MODE_SET, 16'h0005);
        wt(2);
        `CHK("data_clear", 1'b1, dclr)
        host_u.wr(qcfg_pkg::OFS_MODE_CLR, 16'h0004);
        rc(qcfg_pkg::OFS_MODE_SET, 16'h4881);
        `CHK("data_clear", 1'b0, dclr)
        host_u.wr(qcfg_pkg::OFS_MT_WADDR, 16'h0123);
        host_u.wr(qcfg_pkg::OFS_MT_RADDR, 16'h0055);
        host_u.wr(qcfg_pkg::OFS_TW_UPPER, 16'hbeef);
        host_u.wr(qcfg_pkg::OFS_TW_LOWER, 16'h1234);
        wt(2);
        `CHK("memwr", {1'b1, 11'h123, 32'hbeef1234}, mw_q)
        `CHK("mt_raddr", 11'h055, mt_raddr)
        host_u.wr(qcfg_pkg::OFS_MODE_CLR, 16'h0001);
        host_u.wr(qcfg_pkg::OFS_TW_LOWER, 16'h5678);
        wt(3);
        `CHK("commits", 1, mw_n)
        host_u.wr(qcfg_pkg::OFS_CRATE, 16'h00a7);
        host_u.wr(qcfg_pkg::OFS_PED, 16'h0078);
        host_u.wr(qcfg_pkg::OFS_SLIDE, 16'h003c);
        rc(qcfg_pkg::OFS_CRATE, 16'h00a7);
        rc(qcfg_pkg::OFS_PED, 16'h0078);
        rc(qcfg_pkg::OFS_SLIDE, 16'h003c);
        `CHK("crate_out", 8'ha7, crate)
        `CHK("ped_out", 8'h78, ped)
        `CHK("dac_on", 8'h00, dac)
        host_u.wr(qcfg_pkg::OFS_MODE_CLR, 16'h0080);
        wt(2);
        `CHK("dac_off", 8'h3c, dac)
        host_u.wr(qcfg_pkg::OFS_TEST_CONV, 16'h0000);
        inc = 1'b1;
        wt(3);
        inc = 1'b0;
        wt(2);
        `CHK("conv", 1, cv_n)
        `CHK("evcnt", 24'h000003, evc)
        host_u.wr(qcfg_pkg::OFS_EVCNT_CLR, 16'h5a5a);
        wt(2);
        `CHK("evcnt_clr", 24'h000000, evc)
        rc(qcfg_pkg::OFS_ADC_A, 16'h0abc);
        host_u.wr(qcfg_pkg::OFS_ADC_B, 16'h1111);
        rc(qcfg_pkg::OFS_ADC_B, 16'h0def);
        host_u.wr(16'h108a, 16'h0123);
        thr_sel = 5'h05;
        wt(2);
        `CHK("thr", {1'b1, 16'h0123}, {kill, thr})
        narrow = 1'b1;
        host_u.wr(16'h1084, 16'h0042);
        rc(16'h1084, 16'h0042);
        narrow = 1'b0;
        sys_rst_in = 1'b1;
        wt(1);
        sys_rst_in = 1'b0;
        rc(16'h108a, 16'h0123);
        rc(qcfg_pkg::OFS_MODE_SET, qcfg_pkg::MODE_RST);
        foreach (RA[i]) rc(RA[i], {8'h00, RV[i]});
        rc(16'h2000, 16'h0000);
        host_u.wr(qcfg_pkg::OFS_CRATE, 16'h0066);
        hw_rst = 1'b1;
        wt(1);
        hw_rst = 1'b0;
        rc(qcfg_pkg::OFS_CRATE, 16'h0000);
        rc(16'h108a, 16'h0123);
        host_u.wr(qcfg_pkg::OFS_MODE_SET, 16'h0040);
        host_u.wr(qcfg_pkg::OFS_MODE_CLR, 16'h0040);
        // exactly 32 words in channel order
        for (int i = 0; i < 32; i++) host_u.wr(qcfg_pkg::OFS_TEST_EVT, 16'h1000 + 16'(i * 7));
        host_u.wr(qcfg_pkg::OFS_MODE_SET, 16'h0040);
        gate = 1'b1;
        wt(4);
        gate = 1'b0;
        wt(4);
        `CHK("acq_word", 13'h1000, mw_a.data[12:0])
        gate = 1'b1;
        wt(4);
        gate = 1'b0;
        wt(4);
        `CHK("acq_next", {1'b1, 11'h001, 32'h00001007}, mw_q)
        results;
    end
endmodule : tb_qcfg_regs
bind qcfg_regs qcfg_regs_checker chk_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .hw_rst_in(hw_rst_in), .req_in(req_in), .evt_inc_in(evt_inc_in), .mode_out(mode_out),
    .dac_out(dac_out), .conv_start_out(conv_start_out), .data_clear_out(data_clear_out),
    .evt_count_out(evt_count_out), .memwr_out(memwr_out));
